//--- include/ddq_pkg.sv
// Constants for the de-gamma and dither quantiser: register map, field
// layout, reset values, pipeline widths and FIFO sizing.
// Assumes a single 25 MHz clock domain shared by bus, pixel source and sink.
package ddq_pkg;
	// Register byte addresses on the AXI4-Lite slave
	localparam logic [31:0] ADDR_CTRL  = 32'h0000_0000;
	localparam logic [31:0] ADDR_STAT  = 32'h0000_0004;
	localparam logic [31:0] ADDR_GIDX  = 32'h0000_0008;
	localparam logic [31:0] ADDR_GDAT  = 32'h0000_000C;
	// Control fields
	localparam int          CTRL_TEN_BIT   = 0;
	localparam int          CTRL_DEPTH_LSB = 8;
	localparam int          CTRL_DEPTH_W   = 4;
	localparam logic [31:0] CTRL_RST       = 32'h0000_0401;
	localparam logic [31:0] CTRL_MASK      = 32'h0000_0F01;
	// Status fields
	localparam int          STAT_OX_LSB  = 0;
	localparam int          STAT_OY_LSB  = 4;
	localparam int          STAT_LVL_LSB = 8;
	localparam int          STAT_FRM_LSB = 16;
	// Bus responses
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// Pixel path
	localparam int          PIX_W   = 8;
	localparam int          DG_W    = 12;
	localparam logic [12:0] DG_FULL = 13'h1000;
	localparam int          LVL_W   = 8;
	localparam int          CRD_W   = 11;
	localparam int          MSK_W   = 3;
	localparam logic [2:0]  ROT_DX  = 3'h3;
	localparam logic [2:0]  ROT_DY  = 3'h5;
	localparam logic [3:0]  DEPTH_MIN = 4'h1;
	localparam logic [3:0]  DEPTH_MAX = 4'h8;
	// Buffering
	localparam int          FIFO_W     = LVL_W + 2;
	localparam int          FIFO_DEPTH = 16;
	localparam logic [4:0]  SRDY_LIMIT = 5'h0B;
endpackage : ddq_pkg

//--- design/ddq_top.sv
// De-gamma lookup, ordered-dither quantiser and output FIFO for one pixel
// stream, with an AXI4-Lite register slave for control and table loading.
// Assumes source, sink and bus share aclk; pixels arrive with frame-start
// and line-end markers on the same beat.
//
// Behaviour
// - Threshold per pixel comes from a mask indexed by its x,y coordinates.
// - Fraction gives position between lower and upper native level.
// - Fraction exactly zero outputs the bounding level with no dither.
// - Fraction strictly above threshold selects the upper level.
// - Fraction at or below threshold selects the lower level.
// - Mask pattern makes neighbouring thresholds differ as much as possible.
// - Temporal dither rotates the mask once per frame.
// - A control bit enables temporal dither; off keeps mask fixed.
// - Result depends only on own pixel and coordinates, within one step.
// - Zero stays zero and full scale stays full scale.
// - A programmable de-gamma table maps every pixel except codes 0 and 255 before output.
// - De-gamma output is wider than the 8-bit input.
// - De-gamma comes first, dither second.
// - Table holds 256 entries; code 0 maps to 0, 255 to full scale.
// - Output is a native level index for the sequencer bit planes.
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module ddq_fifo
#(
	parameter int W     = ddq_pkg::FIFO_W,
	parameter int DEPTH = ddq_pkg::FIFO_DEPTH
)
(
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [W-1:0]               in_data,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	output logic [W-1:0]                    out_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [$clog2(DEPTH):0]          level
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;
	logic [W-1:0]  out_q;
	logic          ov_q;
	wire           wr = in_valid & in_ready;
	// Output register refills whenever it is empty or being drained
	wire           ld = (cnt_q != '0) & (~ov_q | out_ready);

	assign in_ready  = cnt_q != (AW+1)'(DEPTH);
	assign out_data  = out_q;
	assign out_valid = ov_q;
	assign level     = cnt_q;

	always_ff @(posedge aclk)
	begin
		if (wr)
			mem_q[wp_q] <= in_data;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
			out_q <= '0;
			ov_q  <= 1'b0;
		end
		else
		begin
			if (wr)
				wp_q <= wp_q + AW'(1);
			if (ld)
				rp_q <= rp_q + AW'(1);
			cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(ld);
			if (ld)
			begin
				out_q <= mem_q[rp_q];
				ov_q  <= 1'b1;
			end
			else if (out_ready)
				ov_q <= 1'b0;
		end
	end
endmodule : ddq_fifo

module ddq_top
(
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [31:0]                s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [31:0]                s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic [ddq_pkg::PIX_W-1:0]  s_pix,
	input  wire logic                       s_sof,
	input  wire logic                       s_eol,
	input  wire logic                       s_valid,
	output logic                            s_ready,
	output logic [ddq_pkg::LVL_W-1:0]       m_level,
	output logic                            m_sof,
	output logic                            m_eol,
	output logic                            m_valid,
	input  wire logic                       m_ready
);
	import ddq_pkg::*;

	// Ordered mask by bit interleave: neighbours land far apart in value
	function automatic logic [5:0] mask_val(input logic [2:0] x, input logic [2:0] y);
		logic [2:0] d;
		d = x ^ y;
		mask_val = {d[0], y[0], d[1], y[1], d[2], y[2]};
	endfunction : mask_val

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		merge = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				merge[8*b +: 8] = nw[8*b +: 8];
	endfunction : merge

	// Bit depth clamped to 1..8, top level is 2^depth - 1
	function automatic logic [LVL_W-1:0] top_level(input logic [3:0] depth);
		logic [3:0] dc;
		dc = (depth < DEPTH_MIN) ? DEPTH_MIN : ((depth > DEPTH_MAX) ? DEPTH_MAX : depth);
		top_level = LVL_W'((9'h001 << dc) - 9'h001);
	endfunction : top_level

	// Registers and table
	logic [31:0]       ctrl_q;
	logic [PIX_W-1:0]  gidx_q;
	logic [DG_W-1:0]   gamma_q [256];
	logic [15:0]       frm_q;
	logic [MSK_W-1:0]  ox_q;
	logic [MSK_W-1:0]  oy_q;
	wire               ten = ctrl_q[CTRL_TEN_BIT];
	wire [LVL_W-1:0]   lvl_top = top_level(ctrl_q[CTRL_DEPTH_LSB +: CTRL_DEPTH_W]);

	// AXI write channel
	logic [31:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        aw_have_q;
	logic        w_have_q;
	logic        awready_q;
	logic        wready_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	wire aw_hs    = s_axi_awvalid & awready_q;
	wire w_hs     = s_axi_wvalid & wready_q;
	wire wr_fire  = aw_have_q & w_have_q & ~bvalid_q;
	wire aw_have_d = (aw_have_q | aw_hs) & ~wr_fire;
	wire w_have_d  = (w_have_q | w_hs) & ~wr_fire;
	wire bvalid_d  = (bvalid_q & ~s_axi_bready) | wr_fire;
	wire wr_ctrl  = wr_fire & (awaddr_q == ADDR_CTRL);
	wire wr_gidx  = wr_fire & (awaddr_q == ADDR_GIDX);
	wire wr_gdat  = wr_fire & (awaddr_q == ADDR_GDAT);
	wire wr_stat  = wr_fire & (awaddr_q == ADDR_STAT);
	wire wr_ok    = wr_ctrl | wr_gidx | wr_gdat | wr_stat;
	wire [31:0] gdat_new = merge({20'h0_0000, gamma_q[gidx_q]}, wdata_q, wstrb_q);
	wire [31:0] gidx_new = merge({24'h00_0000, gidx_q}, wdata_q, wstrb_q);

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awaddr_q  <= '0;
			wdata_q   <= '0;
			wstrb_q   <= '0;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end
		else
		begin
			if (aw_hs)
				awaddr_q <= s_axi_awaddr;
			if (w_hs)
			begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			awready_q <= ~aw_have_d & ~bvalid_d;
			wready_q  <= ~w_have_d & ~bvalid_d;
			bvalid_q  <= bvalid_d;
			if (wr_fire)
				bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// Control register and table index; data writes auto-advance the index
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q <= CTRL_RST;
			gidx_q <= '0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & CTRL_MASK;
			if (wr_gidx)
				gidx_q <= gidx_new[PIX_W-1:0];
			else if (wr_gdat)
				gidx_q <= gidx_q + PIX_W'(1);
		end
	end

	// Programmable curve, reset to a linear ramp so the path is defined
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 256; i++)
				gamma_q[i] <= DG_W'(i * 16);
		end
		else if (wr_gdat)
			gamma_q[gidx_q] <= gdat_new[DG_W-1:0];
	end

	// AXI read channel, answer one cycle after the address is taken
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic [4:0]  fifo_lvl;
	wire ar_hs    = s_axi_arvalid & arready_q;
	wire rvalid_d = (rvalid_q & ~s_axi_rready) | ar_hs;
	wire [31:0] stat_word = (32'(ox_q) << STAT_OX_LSB) | (32'(oy_q) << STAT_OY_LSB)
		| (32'(fifo_lvl) << STAT_LVL_LSB) | (32'(frm_q) << STAT_FRM_LSB);
	wire rd_ctrl = s_axi_araddr == ADDR_CTRL;
	wire rd_stat = s_axi_araddr == ADDR_STAT;
	wire rd_gidx = s_axi_araddr == ADDR_GIDX;
	wire rd_gdat = s_axi_araddr == ADDR_GDAT;
	wire rd_ok   = rd_ctrl | rd_stat | rd_gidx | rd_gdat;
	wire [31:0] rd_mux = rd_ctrl ? ctrl_q
		: rd_stat ? stat_word
		: rd_gidx ? {24'h00_0000, gidx_q}
		: rd_gdat ? {20'h0_0000, gamma_q[gidx_q]}
		: 32'h0000_0000;

	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= RESP_OKAY;
		end
		else
		begin
			arready_q <= ~rvalid_d;
			rvalid_q  <= rvalid_d;
			if (ar_hs)
			begin
				rdata_q <= rd_mux;
				rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Pixel intake and coordinates; input is one 8-bit code per beat
	logic             srdy_q;
	logic [CRD_W-1:0] x_q;
	logic [CRD_W-1:0] y_q;
	// Offset the current frame started with; the whole frame shares one mask position
	logic [MSK_W-1:0] fx_q;
	logic [MSK_W-1:0] fy_q;
	wire              acc = s_valid & srdy_q;
	wire [CRD_W-1:0]  cx  = s_sof ? '0 : x_q;
	wire [CRD_W-1:0]  cy  = s_sof ? '0 : y_q;
	wire              rot = acc & s_sof & ten;
	// The start pixel already sees the offset it hands on to the rest of its frame
	wire [MSK_W-1:0]  fox = s_sof ? ox_q : fx_q;
	wire [MSK_W-1:0]  foy = s_sof ? oy_q : fy_q;

	assign s_ready = srdy_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			x_q   <= '0;
			y_q   <= '0;
			ox_q  <= '0;
			oy_q  <= '0;
			fx_q  <= '0;
			fy_q  <= '0;
			frm_q <= '0;
		end
		else if (acc)
		begin
			x_q <= s_eol ? '0 : cx + CRD_W'(1);
			y_q <= s_eol ? cy + CRD_W'(1) : cy;
			if (s_sof)
			begin
				frm_q <= frm_q + 16'h0001;
				fx_q  <= ox_q;
				fy_q  <= oy_q;
			end
			if (rot)
			begin
				// Offsets wrap in three bits, i.e. modulo the 8x8 mask
				ox_q <= ox_q + ROT_DX;
				oy_q <= oy_q + ROT_DY;
			end
		end
	end

	// Stage 1: capture pixel and rotated mask coordinates
	logic             v1_q;
	logic [PIX_W-1:0] pix1_q;
	logic [MSK_W-1:0] mx1_q;
	logic [MSK_W-1:0] my1_q;
	logic             sof1_q;
	logic             eol1_q;

	// Stage 2: widened de-gamma value and threshold
	logic             v2_q;
	logic [12:0]      dg2_q;
	logic [DG_W-1:0]  thr2_q;
	logic             sof2_q;
	logic             eol2_q;

	// Stage 3: quantised level feeding the FIFO
	logic             v3_q;
	logic [FIFO_W-1:0] w3_q;
	logic             fifo_in_ready;

	// Endpoints forced so zero and full scale always hit native levels
	wire [12:0] dg_lookup = (pix1_q == 8'h00) ? 13'h0000
		: (pix1_q == 8'hFF) ? DG_FULL
		: {1'b0, gamma_q[pix1_q]};
	// Threshold spans the fraction range, centred in each 1/64 bin
	wire [DG_W-1:0] thr_sel = {mask_val(mx1_q, my1_q), 6'h20};

	// Dither acts on the widened de-gamma value
	wire [20:0]      scaled = {8'h00, dg2_q} * {13'h0000, lvl_top};
	wire [LVL_W-1:0] lo     = scaled[19:12];
	wire [DG_W-1:0]  frac   = scaled[11:0];
	wire             exact  = frac == 12'h000;
	wire             up     = ~exact & (frac > thr2_q);
	// At most one step above the floor, from this pixel alone
	wire [LVL_W-1:0] q_lvl  = up ? lo + LVL_W'(1) : lo;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			v1_q   <= 1'b0;
			pix1_q <= '0;
			mx1_q  <= '0;
			my1_q  <= '0;
			sof1_q <= 1'b0;
			eol1_q <= 1'b0;
			v2_q   <= 1'b0;
			dg2_q  <= '0;
			thr2_q <= '0;
			sof2_q <= 1'b0;
			eol2_q <= 1'b0;
			v3_q   <= 1'b0;
			w3_q   <= '0;
		end
		else
		begin
			v1_q   <= acc;
			pix1_q <= s_pix;
			mx1_q  <= cx[MSK_W-1:0] + fox;
			my1_q  <= cy[MSK_W-1:0] + foy;
			sof1_q <= s_sof;
			eol1_q <= s_eol;
			v2_q   <= v1_q;
			dg2_q  <= dg_lookup;
			thr2_q <= thr_sel;
			sof2_q <= sof1_q;
			eol2_q <= eol1_q;
			v3_q   <= v2_q;
			w3_q   <= {sof2_q, eol2_q, q_lvl};
		end
	end

	// Intake stops early enough that pixels in flight always find room
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			srdy_q <= 1'b0;
		else
			srdy_q <= fifo_lvl <= SRDY_LIMIT;
	end

	logic [FIFO_W-1:0] fifo_out;

	ddq_fifo #(
		.W     (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_data   (w3_q),
		.in_valid  (v3_q & fifo_in_ready),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out),
		.out_valid (m_valid),
		.out_ready (m_ready),
		.level     (fifo_lvl)
	);

	assign m_level = fifo_out[LVL_W-1:0];
	assign m_eol   = fifo_out[LVL_W];
	assign m_sof   = fifo_out[LVL_W+1];
endmodule : ddq_top

`default_nettype wire

//--- sim/ddq_properties.sv
// Checker for the quantiser's bus handshakes, stream hold and reset behaviour.
// Sees only ddq_top ports; attached by the bind after the module.
`timescale 1ns/1ps
`default_nettype none
module ddq_props
	import ddq_pkg::*;
(
	input wire logic                      aclk,
	input wire logic                      aresetn,
	input wire logic                      s_axi_awvalid,
	input wire logic                      s_axi_awready,
	input wire logic                      s_axi_wvalid,
	input wire logic                      s_axi_wready,
	input wire logic [1:0]                s_axi_bresp,
	input wire logic                      s_axi_bvalid,
	input wire logic                      s_axi_bready,
	input wire logic                      s_axi_arvalid,
	input wire logic                      s_axi_arready,
	input wire logic [31:0]               s_axi_rdata,
	input wire logic [1:0]                s_axi_rresp,
	input wire logic                      s_axi_rvalid,
	input wire logic                      s_axi_rready,
	input wire logic                      s_valid,
	input wire logic                      s_ready,
	input wire logic [ddq_pkg::LVL_W-1:0] m_level,
	input wire logic                      m_sof,
	input wire logic                      m_eol,
	input wire logic                      m_valid,
	input wire logic                      m_ready
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	rst_quiet_a: assert property ($rose(aresetn) |-> !s_ready && !m_valid && !s_axi_bvalid
		&& !s_axi_rvalid) else $error("output active after reset");
	rst_ready_a: assert property ($rose(aresetn) |=> s_ready && s_axi_awready && s_axi_wready
		&& s_axi_arready) else $error("ready missing after reset");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response not held");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable({s_axi_rdata, s_axi_rresp})) else $error("read data not held");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
		&& !s_axi_arready) else $error("read answer late");
	err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
		|-> s_axi_rdata == 32'h0000_0000) else $error("error read not zero");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("ready during pending response");
	lvl_hold_a: assert property (m_valid && !m_ready |=> m_valid
		&& $stable({m_level, m_sof, m_eol})) else $error("level not held");
	pix_latency_a: assert property (s_valid && s_ready && !m_valid
		|-> ##[5:6] m_valid) else $error("pixel result late");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	c_stall: cover property (m_valid && !m_ready);
	c_full: cover property ($fell(s_ready));
endmodule : ddq_props
bind ddq_top ddq_props u_props (.*);
`default_nettype wire

//--- sim/ddq_src_model.sv
// Upstream pixel source: offers one 8-bit pixel at a time with frame markers.
// Assumes the sink samples ready on the rising edge of aclk.
`timescale 1ns/1ps
`default_nettype none
module ddq_src
	import ddq_pkg::*;
(
	input  wire logic                      aclk,
	output logic [ddq_pkg::PIX_W-1:0]      s_pix,
	output logic                           s_sof,
	output logic                           s_eol,
	output logic                           s_valid,
	input  wire logic                      s_ready
);
	logic hung = 1'b0;
	initial
	begin
		s_pix = 8'h00;
		s_sof = 1'b0;
		s_eol = 1'b0;
		s_valid = 1'b0;
	end
	// Only whole 8-bit codes are ever offered
	task automatic send(input logic [7:0] p, input logic sof, input logic eol);
		int n;
		s_pix <= p;
		s_sof <= sof;
		s_eol <= eol;
		s_valid <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (s_ready !== 1'b1 && n < 200);
		hung = (s_ready !== 1'b1);
	endtask : send
	// Released lines flip so stale data cannot pass for a fresh pixel
	task automatic stop();
		s_valid <= 1'b0;
		s_pix <= ~s_pix;
		s_sof <= ~s_sof;
		s_eol <= ~s_eol;
		@(posedge aclk);
	endtask : stop
endmodule : ddq_src
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for ddq_top: bus, dither maths, rotation, table, FIFO.
// Assumes the source model ddq_src and the bound checker ddq_props.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ddq_pkg::*;
	typedef struct {logic [7:0] pix; logic sof; logic eol; logic [7:0] lvl;} ddq_row_t;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000;
	logic [31:0] s_axi_araddr = 32'h0000_0000, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, m_ready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  s_pix, m_level;
	logic        s_sof, s_eol, s_valid, s_ready, m_sof, m_eol, m_valid;
	logic [9:0]  got [$];
	int          n_mismatch = 0;
	int          n_tests = 0;
	// Line 0 of frame 0, depth 4, linear table: thresholds 32,2080,544,2592,160,2208,672,2720
	ddq_row_t rows [8] = '{'{8'h00, 1'b1, 1'b0, 8'h00}, '{8'h11, 1'b0, 1'b0, 8'h01},
		'{8'h12, 1'b0, 1'b0, 8'h01}, '{8'hFF, 1'b0, 1'b0, 8'h0F}, '{8'h34, 1'b0, 1'b0, 8'h04},
		'{8'h80, 1'b0, 1'b0, 8'h07}, '{8'h45, 1'b0, 1'b0, 8'h04}, '{8'hFC, 1'b0, 1'b1, 8'h0F}};
	ddq_top dut (.*);
	ddq_src src (.*);
	always #20 aclk = ~aclk;
	always @(posedge aclk)
		if (m_valid && m_ready) got.push_back({m_sof, m_eol, m_level});
	task automatic final_report();
		if (n_mismatch == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	task automatic give_up();
		n_mismatch++;
		final_report();
	endtask : give_up
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want)
		begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : chk
	task automatic wchk(input logic [31:0] a, input logic [31:0] d, input logic [1:0] want);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++)
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		if (n == 50) give_up();
		s_axi_bready <= 1'b0;
		chk({30'h0000_0000, s_axi_bresp}, {30'h0000_0000, want});
	endtask : wchk
	task automatic rchk(input logic [31:0] a, input logic [31:0] want, input logic [1:0] wr);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++)
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		if (n == 50) give_up();
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, want);
		chk({30'h0000_0000, s_axi_rresp}, {30'h0000_0000, wr});
	endtask : rchk
	task automatic px(input logic [7:0] p, input logic sof, input logic eol);
		src.send(p, sof, eol);
		if (src.hung) give_up();
	endtask : px
	task automatic take(input logic [9:0] want);
		int n;
		for (n = 0; n < 100 && got.size() == 0; n++)
			@(posedge aclk);
		if (got.size() == 0) give_up();
		chk({22'h00_0000, got.pop_front()}, {22'h00_0000, want});
	endtask : take
	initial
	begin
		int k;
		repeat (6) @(posedge aclk);
		chk({28'h000_0000, s_ready, m_valid, s_axi_bvalid, s_axi_rvalid}, 32'h0000_0000);
		aresetn <= 1'b1;
		m_ready <= 1'b1;
		rchk(ADDR_CTRL, CTRL_RST, RESP_OKAY);
		foreach (rows[i]) px(rows[i].pix, rows[i].sof, rows[i].eol);
		src.stop();
		foreach (rows[i]) take({rows[i].sof, rows[i].eol, rows[i].lvl});
		// Rotated mask moves the threshold under this pixel from 32 to 1760
		px(8'h34, 1'b1, 1'b1);
		src.stop();
		take(10'h303);
		wchk(ADDR_CTRL, 32'hFFFF_F400, RESP_OKAY);
		rchk(ADDR_CTRL, 32'h0000_0400, RESP_OKAY);
		// Fraction 432 clears the fixed threshold 416 but not the 2016 a rotation would give
		px(8'h35, 1'b1, 1'b1);
		px(8'h35, 1'b1, 1'b1);
		src.stop();
		take(10'h304);
		take(10'h304);
		rchk(ADDR_STAT, 32'h0004_0026, RESP_OKAY);
		wchk(ADDR_CTRL, 32'h0000_0100, RESP_OKAY);
		wchk(ADDR_GIDX, 32'h0000_00FF, RESP_OKAY);
		wchk(ADDR_GDAT, 32'h0000_0FFF, RESP_OKAY);
		rchk(ADDR_GIDX, 32'h0000_0000, RESP_OKAY);
		// Entry 154 lifted from 2464 (equal to its threshold, rounds down) to 2470, still monotonic
		wchk(ADDR_GIDX, 32'h0000_009A, RESP_OKAY);
		wchk(ADDR_GDAT, 32'h0000_09A6, RESP_OKAY);
		rchk(ADDR_GDAT, 32'h0000_09B0, RESP_OKAY);
		px(8'h14, 1'b1, 1'b0);
		px(8'h9A, 1'b0, 1'b0);
		px(8'hFF, 1'b0, 1'b1);
		src.stop();
		take(10'h200);
		take(10'h001);
		take(10'h101);
		wchk(32'h0000_0010, 32'h0000_0001, RESP_SLVERR);
		rchk(32'h0000_0010, 32'h0000_0000, RESP_SLVERR);
		// Sink stalls until the source is refused, then drains everything
		m_ready <= 1'b0;
		k = 0;
		do
		begin
			px(8'h00, 1'b0, 1'b0);
			src.stop();
			k++;
		end
		while (s_ready === 1'b1 && k < 40);
		chk({31'h0000_0000, s_ready}, 32'h0000_0000);
		m_ready <= 1'b1;
		repeat (k) take(10'h000);
		rchk(ADDR_STAT, 32'h0005_0026, RESP_OKAY);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(ADDR_CTRL, CTRL_RST, RESP_OKAY);
		final_report();
	end
endmodule : tb
`default_nettype wire
